// *** include/card_cmd_pkg.sv ***
package card_cmd_pkg;

    // frame layout on the command line, host and card frames alike
    localparam logic [5:0] FRAME_BITS    = 6'h30;
    localparam int         BLK_LEN_W     = 12;
    localparam logic       START_BIT     = 1'b0;
    localparam logic       END_BIT       = 1'b1;
    localparam logic       HOST_DIR      = 1'b1;
    localparam logic       CARD_DIR      = 1'b0;
    localparam logic       FAST_DIR      = 1'b1;   // fast register and interrupt answers carry a one here
    localparam logic [6:0] CRC7_POLY     = 7'h09;
    localparam logic [6:0] CRC7_INIT     = 7'h00;

    // command indexes of the upper range
    localparam logic [5:0] IDX_FIRST_UPPER = 6'h27;
    localparam logic [5:0] IDX_FAST_REG    = 6'h27;
    localparam logic [5:0] IDX_GO_IRQ      = 6'h28;
    localparam logic [5:0] IDX_LOCK        = 6'h2a;
    localparam logic [5:0] IDX_APP_PREFIX  = 6'h37;
    localparam logic [5:0] IDX_GEN_BLOCK   = 6'h38;

    // argument fields
    localparam int ARG_RCA_HI  = 31;
    localparam int ARG_RCA_LO  = 16;
    localparam int ARG_WR_FLAG = 15;
    localparam int ARG_REG_HI  = 14;
    localparam int ARG_REG_LO  = 8;
    localparam int ARG_DATA_HI = 7;
    localparam int ARG_DATA_LO = 0;
    localparam int GEN_RW_BIT  = 0;

    typedef enum logic [1:0] {
        KIND_LOCK,
        KIND_LOWER
    } record_kind_type;

    // one command handed on to the data-block logic
    typedef struct packed {
        record_kind_type        kind;
        logic [5:0]             index;
        logic [31:0]            arg;
        logic [BLK_LEN_W-1:0]   block_len;
    } cmd_record_type;

endpackage : card_cmd_pkg

// *** verilog/card_cmd_decode_io_lock_app.sv ***
`timescale 1ns/1ps
module cmd_record_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    always_comb begin
        in_ready    = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
        out_valid   = wr_ptr != rd_ptr;
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage needs no reset, only pointers do
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : cmd_record_fifo

module card_cmd_decode_io_lock_app #(
    parameter logic IO_CLASS_EN = 1'b0,   // the io class is left out of this card
    parameter int   FIFO_DEPTH  = 32,
    parameter int   FAST_REGS   = 128
) (
    input  wire logic                                core_clk,
    input  wire logic                                arst_n,
    input  wire logic                                link_clk,
    input  wire logic                                cmd_in,
    output logic                                     cmd_out,
    output logic                                     cmd_oe_n,
    output logic                                     dat0_out,
    output logic                                     dat0_oe_n,
    input  wire logic [15:0]                         card_rca,
    input  wire logic [31:0]                         card_status,
    input  wire logic [card_cmd_pkg::BLK_LEN_W-1:0]  block_len,
    input  wire logic                                lock_busy,
    input  wire logic                                irq_request,
    input  wire logic [15:0]                         irq_data,
    output logic                                     rec_valid,
    input  wire logic                                rec_ready,
    output card_cmd_pkg::cmd_record_type             rec,
    output logic                                     irq_mode,
    output logic                                     illegal_cmd
);
    typedef enum logic [1:0] {ST_RX, ST_PUSH, ST_RESP, ST_BUSY} state_type;

    function automatic logic [6:0] crc7(input logic [39:0] bits);
        logic [6:0] c;
        logic       fb;
        c = card_cmd_pkg::CRC7_INIT;
        for (int i = 39; i >= 0; i--) begin
            fb = bits[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? card_cmd_pkg::CRC7_POLY : 7'h00);
        end
        return c;
    endfunction : crc7

    function automatic logic [47:0] build_resp(input logic dir, input logic [5:0] idx, input logic [31:0] arg);
        logic [39:0] head;
        head = {card_cmd_pkg::START_BIT, dir, idx, arg};
        return {head, crc7(head), card_cmd_pkg::END_BIT};
    endfunction : build_resp

    logic [2:0]  clk_sync;    // [0] first stage, read only by [1]
    logic [1:0]  cmd_sync;
    logic [7:0]  fast_reg [FAST_REGS];
    state_type   state, next_state;
    logic [47:0] rx_shift, next_rx_shift, tx_shift, next_tx_shift;
    logic [5:0]  rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
    logic        resp_busy, next_resp_busy, next_irq_mode, next_illegal_cmd;
    logic        next_cmd_out, next_cmd_oe_n, next_dat0_oe_n;
    logic        clk_rise, clk_fall, frame_ok, rca_hit, fast_we, fifo_in_ready;
    logic [5:0]  rx_index;
    logic [31:0] rx_arg;
    logic [6:0]  reg_addr;
    card_cmd_pkg::cmd_record_type pend, next_pend;
    logic [$bits(card_cmd_pkg::cmd_record_type)-1:0] fifo_out;

    // link clock crosses in through three flops, command pin through two
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sync <= 3'h0;
            cmd_sync <= 2'h3;
        end else begin
            clk_sync <= {clk_sync[1:0], link_clk};
            cmd_sync <= {cmd_sync[0], cmd_in};
        end
    end

    // records wait here while the data-block side is slow
    cmd_record_fifo #(
        .WIDTH ($bits(card_cmd_pkg::cmd_record_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .in_valid  (state == ST_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (pend),
        .out_valid (rec_valid),
        .out_ready (rec_ready),
        .out_data  (fifo_out)
    );
    assign rec      = card_cmd_pkg::cmd_record_type'(fifo_out);
    assign dat0_out = 1'b0;                                   // busy is always a low level

    // frame checks and argument fields
    always_comb begin
        clk_rise = clk_sync[1] && !clk_sync[2];
        clk_fall = !clk_sync[1] && clk_sync[2];
        rx_index = rx_shift[45:40];
        rx_arg   = rx_shift[39:8];
        reg_addr = rx_arg[card_cmd_pkg::ARG_REG_HI:card_cmd_pkg::ARG_REG_LO];
        rca_hit  = rx_arg[card_cmd_pkg::ARG_RCA_HI:card_cmd_pkg::ARG_RCA_LO] == card_rca;
        frame_ok = rx_shift[47] == card_cmd_pkg::START_BIT && rx_shift[46] == card_cmd_pkg::HOST_DIR
                   && rx_shift[0] == card_cmd_pkg::END_BIT && rx_shift[7:1] == crc7(rx_shift[47:8]);
    end

    // receive, decode, queue, answer
    always_comb begin
        next_state       = state;
        next_rx_shift    = rx_shift;
        next_rx_cnt      = rx_cnt;
        next_tx_shift    = tx_shift;
        next_tx_cnt      = tx_cnt;
        next_resp_busy   = resp_busy;
        next_irq_mode    = irq_mode;
        next_illegal_cmd = 1'b0;
        next_cmd_out     = cmd_out;
        next_cmd_oe_n    = cmd_oe_n;
        next_dat0_oe_n   = 1'b1;
        next_pend        = pend;
        fast_we          = 1'b0;
        case (state)
            ST_RX: begin
                if (rx_cnt == card_cmd_pkg::FRAME_BITS) begin
                    next_rx_cnt = 6'h00;
                    if (frame_ok) begin
                        next_pend = '{card_cmd_pkg::KIND_LOWER, rx_index, rx_arg, block_len};
                        if (rx_index < card_cmd_pkg::IDX_FIRST_UPPER) begin
                            next_state = ST_PUSH;
                        end else if (rx_index == card_cmd_pkg::IDX_FAST_REG && IO_CLASS_EN) begin
                            if (rca_hit) begin
                                fast_we       = rx_arg[card_cmd_pkg::ARG_WR_FLAG];
                                next_tx_shift = build_resp(card_cmd_pkg::FAST_DIR, rx_index,
                                                {card_rca, 1'b0, reg_addr, fast_reg[reg_addr]});
                                next_resp_busy = 1'b0;
                                next_state     = ST_RESP;
                            end
                        end else if (rx_index == card_cmd_pkg::IDX_GO_IRQ && IO_CLASS_EN) begin
                            next_irq_mode = 1'b1;
                        end else if (rx_index == card_cmd_pkg::IDX_LOCK) begin
                            next_pend.kind = card_cmd_pkg::KIND_LOCK;
                            next_state     = ST_PUSH;
                        end else begin
                            next_illegal_cmd = 1'b1;
                        end
                    end
                end else if (irq_mode && irq_request && rx_cnt == 6'h00) begin
                    next_irq_mode = 1'b0;
                    next_tx_shift = build_resp(card_cmd_pkg::FAST_DIR, card_cmd_pkg::IDX_FAST_REG,
                                               {card_rca, irq_data});
                    next_resp_busy = 1'b0;
                    next_state     = ST_RESP;
                end else if (clk_rise && (rx_cnt != 6'h00 || cmd_sync[1] == card_cmd_pkg::START_BIT)) begin
                    next_rx_shift = {rx_shift[46:0], cmd_sync[1]};
                    next_rx_cnt   = rx_cnt + 6'h01;
                end
            end
            ST_PUSH: begin
                // stalls the command path until the queue takes the record
                if (fifo_in_ready) begin
                    if (pend.kind == card_cmd_pkg::KIND_LOCK) begin
                        next_tx_shift  = build_resp(card_cmd_pkg::CARD_DIR, pend.index, card_status);
                        next_resp_busy = 1'b1;
                        next_state     = ST_RESP;
                    end else begin
                        next_state = ST_RX;
                    end
                end
            end
            ST_RESP: begin
                // card drives on the falling link edge, host samples on the rising one
                if (clk_fall) begin
                    if (tx_cnt == card_cmd_pkg::FRAME_BITS) begin
                        next_cmd_oe_n = 1'b1;
                        next_cmd_out  = 1'b1;
                        next_tx_cnt   = 6'h00;
                        next_state    = resp_busy ? ST_BUSY : ST_RX;
                    end else begin
                        next_cmd_oe_n = 1'b0;
                        next_cmd_out  = tx_shift[47];
                        next_tx_shift = {tx_shift[46:0], 1'b0};
                        next_tx_cnt   = tx_cnt + 6'h01;
                    end
                end
            end
            ST_BUSY: begin
                // held until the block is drained and the user side is done
                next_dat0_oe_n = 1'b0;
                if (!lock_busy && !rec_valid) begin
                    next_dat0_oe_n = 1'b1;
                    next_state     = ST_RX;
                end
            end
            default: next_state = ST_RX;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= ST_RX;
            rx_shift    <= 48'h0;
            rx_cnt      <= 6'h00;
            tx_shift    <= 48'h0;
            tx_cnt      <= 6'h00;
            resp_busy   <= 1'b0;
            irq_mode    <= 1'b0;
            illegal_cmd <= 1'b0;
            cmd_out     <= 1'b1;
            cmd_oe_n    <= 1'b1;
            dat0_oe_n   <= 1'b1;
            pend        <= '0;
        end else begin
            state       <= next_state;
            rx_shift    <= next_rx_shift;
            rx_cnt      <= next_rx_cnt;
            tx_shift    <= next_tx_shift;
            tx_cnt      <= next_tx_cnt;
            resp_busy   <= next_resp_busy;
            irq_mode    <= next_irq_mode;
            illegal_cmd <= next_illegal_cmd;
            cmd_out     <= next_cmd_out;
            cmd_oe_n    <= next_cmd_oe_n;
            dat0_oe_n   <= next_dat0_oe_n;
            pend        <= next_pend;
        end
    end

    // fast registers have no fixed meaning; only host fast register commands read and write them
    always_ff @(posedge core_clk) begin
        if (fast_we) begin
            fast_reg[reg_addr] <= rx_arg[card_cmd_pkg::ARG_DATA_HI:card_cmd_pkg::ARG_DATA_LO];
        end
    end

    sequence s_done(logic [5:0] idx);
        state == ST_RX && rx_cnt == card_cmd_pkg::FRAME_BITS && frame_ok && rx_index == idx;
    endsequence

    property p_fast_write;
        @(posedge core_clk) disable iff (!arst_n)
        s_done(card_cmd_pkg::IDX_FAST_REG) ##0 (IO_CLASS_EN && rca_hit && rx_arg[card_cmd_pkg::ARG_WR_FLAG])
        |=> fast_reg[$past(reg_addr)] == $past(rx_arg[card_cmd_pkg::ARG_DATA_HI:card_cmd_pkg::ARG_DATA_LO]);
    endproperty
    a_fast_write: assert property (p_fast_write) else $error("fast register write lost");

    property p_fast_answer;
        @(posedge core_clk) disable iff (!arst_n)
        s_done(card_cmd_pkg::IDX_FAST_REG) ##0 (IO_CLASS_EN && rca_hit)
        |=> state == ST_RESP && tx_shift[45:40] == card_cmd_pkg::IDX_FAST_REG
            && tx_shift[22:16] == $past(reg_addr) && tx_shift[39:24] == card_rca;
    endproperty
    a_fast_answer: assert property (p_fast_answer) else $error("fast register answer malformed");

    property p_io_class_refused;
        @(posedge core_clk) disable iff (!arst_n)
        (s_done(card_cmd_pkg::IDX_FAST_REG) or s_done(card_cmd_pkg::IDX_GO_IRQ)) ##0 !IO_CLASS_EN
        |=> illegal_cmd && state == ST_RX && $stable(irq_mode);
    endproperty
    a_io_class_refused: assert property (p_io_class_refused) else $error("io class command acted on");

    property p_app_refused;
        @(posedge core_clk) disable iff (!arst_n)
        s_done(card_cmd_pkg::IDX_APP_PREFIX) or s_done(card_cmd_pkg::IDX_GEN_BLOCK)
        |=> illegal_cmd && state == ST_RX ##1 state == ST_RX;
    endproperty
    a_app_refused: assert property (p_app_refused) else $error("application command acted on");

    property p_reserved_ignored;
        @(posedge core_clk) disable iff (!arst_n)
        state == ST_RX && rx_cnt == card_cmd_pkg::FRAME_BITS && frame_ok && rx_index > card_cmd_pkg::IDX_GO_IRQ
        && rx_index != card_cmd_pkg::IDX_LOCK && rx_index != card_cmd_pkg::IDX_APP_PREFIX
        && rx_index != card_cmd_pkg::IDX_GEN_BLOCK
        |=> illegal_cmd && cmd_oe_n && state == ST_RX && $stable(irq_mode);
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved index acted on");

    property p_lock_queued;
        @(posedge core_clk) disable iff (!arst_n)
        s_done(card_cmd_pkg::IDX_LOCK) |=> state == ST_PUSH && pend.kind == card_cmd_pkg::KIND_LOCK
            && pend.block_len == $past(block_len);
    endproperty
    a_lock_queued: assert property (p_lock_queued) else $error("lock command not queued");

    property p_busy_low;
        @(posedge core_clk) disable iff (!arst_n)
        state == ST_BUSY ##1 state == ST_BUSY |-> !dat0_oe_n && !dat0_out;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy not driven");

    property p_irq_enter;
        @(posedge core_clk) disable iff (!arst_n)
        s_done(card_cmd_pkg::IDX_GO_IRQ) ##0 IO_CLASS_EN |=> irq_mode && !illegal_cmd;
    endproperty
    a_irq_enter: assert property (p_irq_enter) else $error("interrupt mode not entered");
endmodule : card_cmd_decode_io_lock_app

// *** test/card_host_model.sv ***
`timescale 1ns/1ps
module card_host_model (
    output logic      link_clk,
    output logic      cmd_in,
    input  wire logic cmd_out,
    input  wire logic cmd_oe_n
);
    logic host_oe;
    logic host_bit;

    // the line has a pull-up, so a released line reads high
    assign cmd_in = host_oe ? host_bit : ((cmd_oe_n === 1'b0) ? cmd_out : 1'b1);

    // link clock stands low outside frames
    initial begin
        link_clk = 1'b0;
        host_oe  = 1'b0;
        host_bit = 1'b1;
    end

    // whole frame, crc7 over the first 40 bits
    function automatic logic [47:0] make_frame(input logic dir, input logic [5:0] idx, input logic [31:0] arg);
        logic [39:0] head;
        logic [6:0]  crc;
        logic        fb;
        head = {card_cmd_pkg::START_BIT, dir, idx, arg};
        crc  = card_cmd_pkg::CRC7_INIT;
        for (int i = 39; i >= 0; i--) begin
            fb  = head[i] ^ crc[6];
            crc = {crc[5:0], 1'b0} ^ (fb ? card_cmd_pkg::CRC7_POLY : 7'h00);
        end
        return {head, crc, card_cmd_pkg::END_BIT};
    endfunction : make_frame

    // one link period; the card samples on the rise
    task automatic link_cycle();
        #16 link_clk = 1'b1;
        #16 link_clk = 1'b0;
    endtask : link_cycle

    task automatic idle(input int n);
        repeat (n) link_cycle();
    endtask : idle

    // data changes only after a falling edge, so it is stable at the rise
    task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
        logic [47:0] fr;
        fr      = make_frame(card_cmd_pkg::HOST_DIR, idx, arg);
        host_oe = 1'b1;
        for (int i = 47; i >= 0; i--) begin
            host_bit = fr[i];
            link_cycle();
        end
        host_oe  = 1'b0;
        host_bit = 1'b1;
    endtask : send_cmd

    // wait up to 64 periods for a start bit, then take 47 more bits
    task automatic recv(output logic [47:0] fr, output logic got);
        got = 1'b0;
        fr  = '1;
        for (int n = 0; n < 64 && !got; n++) begin
            #16 link_clk = 1'b1;
            got = (cmd_in === 1'b0);
            #16 link_clk = 1'b0;
        end
        if (got) begin
            fr[47] = 1'b0;
            for (int i = 46; i >= 0; i--) begin
                #16 link_clk = 1'b1;
                fr[i] = cmd_in;
                #16 link_clk = 1'b0;
            end
        end
        idle(8);  // trailing periods let the card release the line
    endtask : recv
endmodule : card_host_model

// *** test/test_card_cmd_decode_io_lock_app.sv ***
`timescale 1ns/1ps
module test_card_cmd_decode_io_lock_app;
    logic                                core_clk, arst_n, link_clk, cmd_in, cmd_out, cmd_oe_n;
    logic                                dat0_out, dat0_oe_n, lock_busy, irq_request, rec_valid;
    logic                                rec_ready, irq_mode, illegal_cmd;
    logic [15:0]                         card_rca, irq_data;
    logic [31:0]                         card_status;
    logic [card_cmd_pkg::BLK_LEN_W-1:0]  block_len;
    card_cmd_pkg::cmd_record_type        rec;
    int                                  err_count, total_checks, ill_count, ans_count;

    card_cmd_decode_io_lock_app dut_u (.core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk),
        .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n), .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n),
        .card_rca(card_rca), .card_status(card_status), .block_len(block_len), .lock_busy(lock_busy),
        .irq_request(irq_request), .irq_data(irq_data), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec(rec), .irq_mode(irq_mode), .illegal_cmd(illegal_cmd));
    card_host_model host_u (.link_clk(link_clk), .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n));

    always #2 core_clk = ~core_clk;

    // pulse and drive-cycle tallies, compared as differences
    always @(posedge core_clk) begin
        if (illegal_cmd === 1'b1) ill_count++;
        if (cmd_oe_n === 1'b0) ans_count++;
    end

    task automatic check_val(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_val

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic test_reset();
        check_val("cmd_oe_n", cmd_oe_n, 1'b1);
        check_val("cmd_out", cmd_out, 1'b1);
        check_val("dat0_oe_n", dat0_oe_n, 1'b1);
        check_val("irq_mode", irq_mode, 1'b0);
        check_val("rec_valid", rec_valid, 1'b0);
    endtask : test_reset

    // every index 39..63 but the lock one: pulse only, no answer, no record
    task automatic test_illegal();
        logic [47:0] fr;
        logic        got;
        int          ill0;
        for (int i = 39; i < 64; i++) begin
            if (i == 42) continue;
            ill0 = ill_count;
            host_u.send_cmd(i[5:0], {card_rca, 1'b1, 7'h05, 8'ha5});
            host_u.recv(fr, got);
            check_val("answer sent", got, 1'b0);
            check_val("illegal pulses", ill_count - ill0, 1);
            check_val("irq_mode", irq_mode, 1'b0);
            check_val("rec_valid", rec_valid, 1'b0);
        end
    endtask : test_illegal

    // lock: busy answer, record queued, busy held until drained and idle
    task automatic test_lock();
        logic [47:0] fr;
        logic        got;
        int          n;
        tick();
        block_len   = 12'h200;
        card_status = 32'h00000900;
        lock_busy   = 1'b1;
        host_u.send_cmd(card_cmd_pkg::IDX_LOCK, 32'h0);
        host_u.recv(fr, got);
        check_val("lock answer", got, 1'b1);
        check_val("lock frame", fr, host_u.make_frame(card_cmd_pkg::CARD_DIR, card_cmd_pkg::IDX_LOCK,
            32'h00000900));
        check_val("busy", dat0_oe_n, 1'b0);
        check_val("busy level", dat0_out, 1'b0);
        check_val("rec_valid", rec_valid, 1'b1);
        check_val("kind", rec.kind, card_cmd_pkg::KIND_LOCK);
        check_val("block_len", rec.block_len, 12'h200);
        tick();
        rec_ready = 1'b1;
        tick();
        rec_ready = 1'b0;
        repeat (10) tick();
        check_val("busy held", dat0_oe_n, 1'b0);
        lock_busy = 1'b0;
        for (n = 0; n < 20 && dat0_oe_n !== 1'b1; n++) tick();
        check_val("busy released", dat0_oe_n, 1'b1);
    endtask : test_lock

    // 33 lower commands against a stalled consumer, then drain in order
    task automatic test_fifo();
        int ans0;
        int n;
        tick();
        ans0      = ans_count;
        block_len = 12'h010;
        for (int i = 0; i < 33; i++) begin
            host_u.send_cmd(i[5:0], {i[7:0], 24'hc0ffee});
            host_u.idle(16);
        end
        check_val("no answer to lower", ans_count - ans0, 0);
        for (int i = 0; i < 33; i++) begin
            // one edge between lowering and raising ready again
            tick();
            for (n = 0; n < 200 && rec_valid !== 1'b1; n++) tick();
            check_val("index", rec.index, i[5:0]);
            check_val("arg", rec.arg, {i[7:0], 24'hc0ffee});
            check_val("kind", rec.kind, card_cmd_pkg::KIND_LOWER);
            check_val("block_len", rec.block_len, 12'h010);
            rec_ready = 1'b1;
            tick();
            rec_ready = 1'b0;
        end
        repeat (5) tick();
        check_val("fifo empty", rec_valid, 1'b0);
    endtask : test_fifo

    // spans about 170 us of traffic; a hang beyond this is cut short
    initial begin
        #250us;
        err_count++;
        complete_run();
    end

    initial begin
        core_clk    = 1'b0;
        arst_n      = 1'b0;
        card_rca    = 16'h1234;
        card_status = 32'h0;
        block_len   = 12'h000;
        lock_busy   = 1'b0;
        irq_request = 1'b0;
        irq_data    = 16'h0000;
        rec_ready   = 1'b0;
        err_count   = 0;
        total_checks = 0;
        ill_count   = 0;
        ans_count   = 0;
        repeat (4) @(posedge core_clk);
        #1 arst_n = 1'b1;
        repeat (8) tick();
        test_reset();
        test_illegal();
        test_lock();
        test_fifo();
        complete_run();
    end
endmodule : test_card_cmd_decode_io_lock_app
